// ---- bench/tpoc_chk.sv ----
// port checker for the timer pwm output control block
`timescale 1ns/1ps
module tpoc_chk
	import tpoc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tpoc_pkg::TPOC_ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic [tpoc_pkg::TPOC_DATA_W-1:0] prdata,
	input wire logic async_clock_mode,
	input wire logic fast_peripheral_tick,
	input wire logic compare_match_b,
	input wire logic compare_match_d,
	input wire logic count_at_bottom,
	input wire logic port_dir_b,
	input wire logic port_dir_d,
	input wire logic waveform_out_b,
	input wire logic waveform_out_d,
	input wire logic compare_pin_b_oe_n,
	input wire logic compare_pin_d_oe_n,
	input wire logic timer_tick,
	input wire logic deadtime_tick
);
	localparam logic [11:0] AD_A = {TPOC_IDX_CTRL_A, 2'b00};
	localparam logic [11:0] AD_B = {TPOC_IDX_CTRL_B, 2'b00};
	localparam logic [11:0] AD_C = {TPOC_IDX_CTRL_C, 2'b00};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_FORCE_RD0: assert property (pready && !pwrite && paddr == AD_A |-> prdata[3:2] == 2'b00)
		else $error("force bits read back nonzero");
	AST_PSR_RD0: assert property (pready && !pwrite && paddr == AD_B |-> prdata[6] == 1'b0)
		else $error("prescaler reset bit read back nonzero");
	// guard on past reset: the pin flop still holds its reset value then
	AST_OE_D: assert property ($past(presetn) |-> compare_pin_d_oe_n == !$past(port_dir_d))
		else $error("pin d driver enable does not follow direction bit");
	AST_OE_B: assert property ($past(presetn) |-> compare_pin_b_oe_n == !$past(port_dir_b))
		else $error("pin b driver enable does not follow direction bit");
	AST_WAVE_B: assert property ($changed(waveform_out_b) |-> $past(compare_match_b || count_at_bottom
		|| (psel && penable && pwrite && paddr == AD_A))) else $error("waveform b changed without cause");
	AST_WAVE_D: assert property ($changed(waveform_out_d) |-> $past(compare_match_d || count_at_bottom
		|| (psel && penable && pwrite && paddr == AD_C))) else $error("waveform d changed without cause");
	AST_RST_VALS: assert property ($rose(presetn) |-> !timer_tick && !deadtime_tick
		&& !waveform_out_d && compare_pin_d_oe_n) else $error("outputs not at reset values");
	AST_TICK_BASE: assert property ($past(async_clock_mode) && $past(async_clock_mode, 2)
		&& !$past(fast_peripheral_tick) && !$past(fast_peripheral_tick, 2) |-> !timer_tick && !deadtime_tick)
		else $error("tick without fast timebase pulse");
endmodule

bind tpoc_top tpoc_chk tpoc_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
	.async_clock_mode, .fast_peripheral_tick, .compare_match_b, .compare_match_d, .count_at_bottom, .port_dir_b,
	.port_dir_d, .waveform_out_b, .waveform_out_d, .compare_pin_b_oe_n, .compare_pin_d_oe_n, .timer_tick,
	.deadtime_tick);

// ---- bench/tpoc_load.sv ----
// load model: pin level seen by the external power switch
`timescale 1ns/1ps
module tpoc_load
(
	input wire logic pin,
	input wire logic pin_comp,
	input wire logic oe_n,
	output logic level,
	output logic level_comp
);
	// released pin falls to the load's pull-down, never keeps old value
	assign level = oe_n ? 1'b0 : pin;
	assign level_comp = oe_n ? 1'b0 : pin_comp;
endmodule

// ---- bench/tpoc_tb_top.sv ----
// self-checking bench for the timer pwm output control block
`timescale 1ns/1ps
module tpoc_tb_top;
	import tpoc_pkg::*;
	localparam logic [11:0] RA = {TPOC_IDX_CTRL_A, 2'b00};
	localparam logic [11:0] RB = {TPOC_IDX_CTRL_B, 2'b00};
	localparam logic [11:0] RD = {TPOC_IDX_CTRL_D, 2'b00};
	localparam logic [11:0] RC = {TPOC_IDX_CTRL_C, 2'b00};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic async_clock_mode = 0, fast_peripheral_tick = 0, compare_match_b = 0, compare_match_d = 0;
	logic count_at_bottom = 0, count_down = 0, port_data_b = 0, port_data_d = 1, port_dir_b = 1, port_dir_d = 1;
	logic waveform_out_b, waveform_out_d, compare_pin_b, compare_pin_b_oe_n, compare_pin_d, compare_pin_d_comp;
	logic compare_pin_d_oe_n, timer_tick, deadtime_tick, lvl_b, lvl_d;
	logic [1:0] ph = 0;
	int err_count = 0, comparisons = 0, ntt, ndt;
	// write flag, address, data or expected read, expected error
	logic [31:0] rows [16][4] = '{
		'{0, RA, 0, 0}, '{0, RB, 0, 0}, '{0, RD, 0, 0}, '{0, RC, 0, 0},
		'{1, RA, 'hff, 0}, '{0, RA, 'hf3, 0}, '{0, RC, 'hf0, 0},
		'{1, RC, 'h5e, 0}, '{0, RA, 'h53, 0}, '{0, RC, 'h5c, 0},
		'{1, RB, 'hc0, 0}, '{0, RB, 'h80, 0}, '{1, RD, 'hff, 0}, '{0, RD, 'h03, 0},
		'{0, 'h0a0, 0, 1}, '{0, RA + 12'h1, 0, 1}};
	// first force lands while pwm b is still on, so it must be ignored
	logic [31:0] fb [6] = '{'h24, 'h14, 'h34, 'h24, 'h14, 'h25};
	logic [31:0] fx [6] = '{1, 0, 1, 0, 1, 0};
	// gen, ctrl c, down, match, bottom, wave, pin, complement
	logic [7:0] dr [15][8] = '{
		'{0, 'h04, 0, 1, 0, 0, 1, 1}, '{0, 'h08, 0, 1, 0, 0, 1, 1}, '{0, 'h0c, 0, 1, 0, 1, 0, 1},
		'{0, 'h05, 0, 1, 0, 0, 1, 0}, '{0, 'h05, 0, 0, 1, 1, 0, 1}, '{0, 'h09, 0, 1, 0, 0, 1, 1},
		'{0, 'h0d, 0, 1, 0, 1, 0, 1}, '{0, 'h0d, 0, 0, 1, 0, 1, 1}, '{1, 'h05, 0, 1, 0, 0, 1, 0},
		'{1, 'h05, 1, 1, 0, 1, 0, 1}, '{1, 'h0d, 0, 1, 0, 1, 0, 1}, '{1, 'h01, 0, 0, 0, 1, 1, 1},
		'{1, 'h0d, 1, 1, 0, 0, 1, 1}, '{2, 'h05, 0, 1, 0, 0, 1, 0}, '{3, 'h05, 1, 1, 0, 1, 0, 1}};

	tpoc_top tpoc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.async_clock_mode, .fast_peripheral_tick, .compare_match_a(1'b0), .compare_match_b, .compare_match_d,
		.count_at_bottom, .count_down, .port_data_a(1'b0), .port_data_b, .port_data_d, .port_dir_a(1'b0),
		.port_dir_b, .port_dir_d, .waveform_out_a(), .waveform_out_b, .waveform_out_d, .compare_pin_a(),
		.compare_pin_a_comp(), .compare_pin_a_oe_n(), .compare_pin_b, .compare_pin_b_comp(), .compare_pin_b_oe_n,
		.compare_pin_d, .compare_pin_d_comp, .compare_pin_d_oe_n, .timer_tick, .deadtime_tick);
	tpoc_load tpoc_load_inst (.pin(compare_pin_b), .pin_comp(1'b0), .oe_n(compare_pin_b_oe_n), .level(lvl_b),
		.level_comp());
	tpoc_load tpoc_load_d_inst (.pin(compare_pin_d), .pin_comp(compare_pin_d_comp), .oe_n(compare_pin_d_oe_n),
		.level(lvl_d), .level_comp());

	initial
	begin
		forever #2.5 pclk = ~pclk;
	end

	// fast timebase pulses every fourth cycle
	always @(posedge pclk)
	begin
		ph <= ph + 2'h1;
		fast_peripheral_tick <= ph == 2'h0;
	end

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here; only the watchdog ends a hung transfer
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, e);
	endtask

	// ticks counted over 128 cycles; every period divides it, so phase drops out
	task automatic count(output int t, output int d);
		t = 0;
		d = 0;
		repeat (4) @(posedge pclk);
		repeat (128)
		begin
			@(posedge pclk);
			// an unknown tick must not pass as zero
			t = t + ($isunknown(timer_tick) ? 1000 : int'(timer_tick));
			d = d + ($isunknown(deadtime_tick) ? 1000 : int'(deadtime_tick));
		end
	endtask

	initial
	begin
		#100000;
		err_count++;
		finish_test();
	end

	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i][0][0], rows[i][1][11:0], rows[i][2], rd, e);
			chk(32'(e), rows[i][3]);
			if (rows[i][0] == 32'h0)
				chk(rd, rows[i][2]);
		end
		foreach (fb[i])
		begin
			wr(RA, fb[i]);
			#1;
			chk(32'(waveform_out_b), fx[i]);
			@(posedge pclk);
			#1;
			chk(32'(lvl_b), 32'(fx[i] == 0));
		end
		foreach (dr[i])
		begin
			wr(RD, 32'(dr[i][0]));
			wr(RC, 32'(dr[i][1]));
			@(posedge pclk);
			count_down <= dr[i][2][0];
			compare_match_d <= dr[i][3][0];
			count_at_bottom <= dr[i][4][0];
			@(posedge pclk);
			compare_match_d <= 1'b0;
			count_at_bottom <= 1'b0;
			@(posedge pclk);
			#1;
			chk(32'(waveform_out_d), 32'(dr[i][5]));
			chk(32'(lvl_d), 32'(dr[i][6]));
			chk(32'(compare_pin_d_comp), 32'(dr[i][7]));
		end
		// port mode drives the pin high in the same cycle it is released, so the load alone has to pull it low
		wr(RC, 32'h01);
		port_dir_d <= 1'b0;
		port_dir_b <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		chk(32'(lvl_d), 32'h0);
		chk(32'(compare_pin_d_oe_n), 32'h1);
		chk(32'(compare_pin_b_oe_n), 32'h1);
		for (int k = 0; k < 8; k++)
		begin
			wr(RB, 32'h80 | 32'(k % 4) << 4 | 32'(k));
			count(ntt, ndt);
			chk(32'(ntt), k == 0 ? 32'h0 : 32'h80 >> (k - 1));
			chk(32'(ndt), 32'h80 >> (k % 4));
		end
		// divide by 128 restarted by the strobe: one strobe cycle, 128 ticks, one register cycle
		wr(RB, 32'hc8);
		repeat (130) @(posedge pclk);
		chk(32'(timer_tick), 32'h1);
		async_clock_mode <= 1'b1;
		wr(RB, 32'h81);
		count(ntt, ndt);
		chk(32'(ntt), 32'h20);
		chk(32'(ndt), 32'h20);
		async_clock_mode <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, RB, 32'h0, rd, e);
		chk(rd, 32'h0);
		chk(32'(waveform_out_d), 32'h0);
		finish_test();
	end
endmodule

// ---- logic/tpoc_pkg.sv ----
// constants for the timer pwm output control block
package tpoc_pkg;
	localparam int unsigned TPOC_ADDR_W = 12;
	localparam int unsigned TPOC_DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [9:0] TPOC_IDX_CTRL_A = 10'h020;
	localparam logic [9:0] TPOC_IDX_CTRL_B = 10'h021;
	localparam logic [9:0] TPOC_IDX_CTRL_D = 10'h026;
	localparam logic [9:0] TPOC_IDX_CTRL_C = 10'h027;
	localparam logic [7:0] TPOC_CTRL_RESET = 8'h00;
	// timer_ctrl_a fields
	localparam int unsigned TPOC_A_MODE_A = 6;
	localparam int unsigned TPOC_A_MODE_B = 4;
	localparam int unsigned TPOC_A_FORCE_A = 3;
	localparam int unsigned TPOC_A_FORCE_B = 2;
	localparam int unsigned TPOC_A_PWM_A = 1;
	localparam int unsigned TPOC_A_PWM_B = 0;
	// timer_ctrl_b_clocking fields
	localparam int unsigned TPOC_B_INVERT = 7;
	localparam int unsigned TPOC_B_PSR = 6;
	localparam int unsigned TPOC_B_DT_DIV = 4;
	localparam int unsigned TPOC_B_CLK_SEL = 0;
	// timer_ctrl_c_outputs_d fields
	localparam int unsigned TPOC_C_MODE_A_SH = 6;
	localparam int unsigned TPOC_C_MODE_B_SH = 4;
	localparam int unsigned TPOC_C_MODE_D = 2;
	localparam int unsigned TPOC_C_FORCE_D = 1;
	localparam int unsigned TPOC_C_PWM_D = 0;
	// timer_ctrl_d_gen_mode field
	localparam int unsigned TPOC_D_GEN = 0;
	// output-mode codes
	localparam logic [1:0] TPOC_OM_PORT = 2'h0;
	localparam logic [1:0] TPOC_OM_TOGGLE = 2'h1;
	localparam logic [1:0] TPOC_OM_CLEAR = 2'h2;
	localparam logic [1:0] TPOC_OM_SET = 2'h3;
	// generation-mode codes
	localparam logic [1:0] TPOC_GEN_FAST = 2'h0;
	localparam logic [1:0] TPOC_GEN_PFC = 2'h1;
	localparam logic [1:0] TPOC_GEN_PWM6_SINGLE = 2'h2;
	localparam logic [1:0] TPOC_GEN_PWM6_DUAL = 2'h3;
	// prescaler widths and clock-select codes
	localparam int unsigned TPOC_PRE_W = 14;
	localparam int unsigned TPOC_DT_W = 3;
	localparam logic [3:0] TPOC_CS_STOP = 4'h0;
	localparam logic [3:0] TPOC_CS_DIV1 = 4'h1;
endpackage

// ---- logic/tpoc_prescaler.sv ----
// free-running clock-select and dead-time prescalers
`timescale 1ns/1ps
module tpoc_prescaler
	import tpoc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic base_tick,
	input wire logic prescaler_clear,
	input wire logic [3:0] clk_select,
	input wire logic [1:0] deadtime_div,
	output logic timer_tick_ff,
	output logic deadtime_tick_ff
);
	logic [TPOC_PRE_W-1:0] div_cnt_ff;
	logic [TPOC_DT_W-1:0] dt_cnt_ff;
	logic [TPOC_PRE_W-1:0] tap_mask;
	logic [TPOC_DT_W-1:0] dt_mask;
	logic nxt_timer_tick;
	logic nxt_deadtime_tick;

	// mask of low counter bits that must all be one for the selected tap
	always_comb
	begin
		tap_mask = '0;
		if (clk_select > TPOC_CS_DIV1)
		begin
			tap_mask = TPOC_PRE_W'((15'h1 << (clk_select - TPOC_CS_DIV1)) - 15'h1);
		end
		dt_mask = TPOC_DT_W'((4'h1 << deadtime_div) - 4'h1);
		nxt_timer_tick = (clk_select != TPOC_CS_STOP) && base_tick && ((div_cnt_ff & tap_mask) == tap_mask);
		nxt_deadtime_tick = base_tick && ((dt_cnt_ff & dt_mask) == dt_mask);
	end

	// clearing restarts the division; both prescaler counters are zeroed here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_cnt_ff <= '0;
			dt_cnt_ff <= '0;
		end
		else if (prescaler_clear)
		begin
			div_cnt_ff <= '0;
			dt_cnt_ff <= '0;
		end
		else if (base_tick)
		begin
			div_cnt_ff <= div_cnt_ff + 1'b1;
			dt_cnt_ff <= dt_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_tick_ff <= 1'b0;
			deadtime_tick_ff <= 1'b0;
		end
		else
		begin
			timer_tick_ff <= nxt_timer_tick && !prescaler_clear;
			deadtime_tick_ff <= nxt_deadtime_tick && !prescaler_clear;
		end
	end
endmodule

// ---- logic/tpoc_top.sv ----
// apb register file and compare-output waveform logic for the high-speed timer
//
// Functional notes
// - force b ignored while pwm b enabled
// - force b acts like compare match, no interrupt
// - force uses mode written same cycle
// - force b bit always reads zero
// - pwm enables a/b select pwm operation
// - invert bit inverts true and complementary outputs
// - prescaler reset strobe, self clearing, reads zero
// - dead-time prescaler divides by 1/2/4/8
// - clock select stops or divides up to 16384
// - mode a shadow shares storage both ways
// - mode b shadow shares storage both ways
// - nonzero mode d drives pin from compare
// - complement d only pwm with code 01
// - pin driver only when direction bit set
// - normal mode: toggle, clear, set on match
// - fast pwm: clear on match, set at bottom
// - dual slope: clear up-match, set down-match
// - generation mode field selects pwm flavour
// - pwm enable d selects pwm operation
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module tpoc_top
	import tpoc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tpoc_pkg::TPOC_ADDR_W-1:0] paddr,
	input wire logic [tpoc_pkg::TPOC_DATA_W-1:0] pwdata,
	output logic pready,
	output logic [tpoc_pkg::TPOC_DATA_W-1:0] prdata,
	output logic pslverr,
	input wire logic async_clock_mode,
	input wire logic fast_peripheral_tick,
	input wire logic compare_match_a,
	input wire logic compare_match_b,
	input wire logic compare_match_d,
	input wire logic count_at_bottom,
	input wire logic count_down,
	input wire logic port_data_a,
	input wire logic port_data_b,
	input wire logic port_data_d,
	input wire logic port_dir_a,
	input wire logic port_dir_b,
	input wire logic port_dir_d,
	output logic waveform_out_a,
	output logic waveform_out_b,
	output logic waveform_out_d,
	output logic compare_pin_a,
	output logic compare_pin_a_comp,
	output logic compare_pin_a_oe_n,
	output logic compare_pin_b,
	output logic compare_pin_b_comp,
	output logic compare_pin_b_oe_n,
	output logic compare_pin_d,
	output logic compare_pin_d_comp,
	output logic compare_pin_d_oe_n,
	output logic timer_tick,
	output logic deadtime_tick
);
	import tpoc_pkg::*;

	logic [1:0] out_mode_a_ff;
	logic [1:0] out_mode_b_ff;
	logic [1:0] out_mode_d_ff;
	logic pwm_enable_a_ff;
	logic pwm_enable_b_ff;
	logic pwm_enable_d_ff;
	logic pwm_invert_ff;
	logic [1:0] deadtime_div_ff;
	logic [3:0] clk_select_ff;
	logic [1:0] gen_mode_ff;
	logic prescaler_reset_strobe_ff;
	logic wave_a_ff;
	logic wave_b_ff;
	logic wave_d_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [TPOC_DATA_W-1:0] prdata_ff;
	logic pin_a_ff;
	logic pin_a_comp_ff;
	logic pin_a_oe_n_ff;
	logic pin_b_ff;
	logic pin_b_comp_ff;
	logic pin_b_oe_n_ff;
	logic pin_d_ff;
	logic pin_d_comp_ff;
	logic pin_d_oe_n_ff;
	logic [1:0] nxt_out_mode_a;
	logic [1:0] nxt_out_mode_b;
	logic [1:0] nxt_out_mode_d;
	logic setup_phase;
	logic wr_access;
	logic [9:0] reg_idx;
	logic idx_ok;
	logic wr_a;
	logic wr_b;
	logic wr_c;
	logic wr_d;
	logic force_a;
	logic force_b;
	logic force_d;
	logic base_tick;

	// one aligned word per register; misaligned addresses are unmapped
	function automatic logic map_ok(input logic [TPOC_ADDR_W-1:0] addr);
		logic [9:0] idx;
		idx = addr[TPOC_ADDR_W-1:2];
		map_ok = (addr[1:0] == 2'h0) && (idx == TPOC_IDX_CTRL_A || idx == TPOC_IDX_CTRL_B ||
			idx == TPOC_IDX_CTRL_C || idx == TPOC_IDX_CTRL_D);
	endfunction

	// next waveform value for one channel; force acts as a normal-mode match
	function automatic logic wave_next(
		input logic [1:0] mode,
		input logic pwm_on,
		input logic [1:0] gen,
		input logic wave,
		input logic match,
		input logic force_hit,
		input logic bottom,
		input logic down
	);
		logic set_on_match;
		wave_next = wave;
		set_on_match = (mode == TPOC_OM_SET);
		if (mode == TPOC_OM_PORT)
		begin
			wave_next = wave;
		end
		else if (!pwm_on && (match || force_hit))
		begin
			if (mode == TPOC_OM_TOGGLE)
			begin
				wave_next = !wave;
			end
			else
			begin
				wave_next = set_on_match;
			end
		end
		else if (pwm_on && (gen == TPOC_GEN_FAST || gen == TPOC_GEN_PWM6_SINGLE))
		begin
			if (match)
			begin
				wave_next = set_on_match;
			end
			else if (bottom)
			begin
				wave_next = !set_on_match;
			end
		end
		else if (pwm_on && match)
		begin
			wave_next = down ? !set_on_match : set_on_match;
		end
	endfunction

	assign setup_phase = psel && !penable;
	assign wr_access = psel && penable && pready_ff && pwrite;
	assign reg_idx = paddr[TPOC_ADDR_W-1:2];
	assign idx_ok = map_ok(paddr);
	assign wr_a = wr_access && idx_ok && reg_idx == TPOC_IDX_CTRL_A;
	assign wr_b = wr_access && idx_ok && reg_idx == TPOC_IDX_CTRL_B;
	assign wr_c = wr_access && idx_ok && reg_idx == TPOC_IDX_CTRL_C;
	assign wr_d = wr_access && idx_ok && reg_idx == TPOC_IDX_CTRL_D;

	// shared storage: either register location updates the same field
	always_comb
	begin
		nxt_out_mode_a = out_mode_a_ff;
		nxt_out_mode_b = out_mode_b_ff;
		nxt_out_mode_d = out_mode_d_ff;
		if (wr_a)
		begin
			nxt_out_mode_a = pwdata[TPOC_A_MODE_A +: 2];
			nxt_out_mode_b = pwdata[TPOC_A_MODE_B +: 2];
		end
		else if (wr_c)
		begin
			nxt_out_mode_a = pwdata[TPOC_C_MODE_A_SH +: 2];
			nxt_out_mode_b = pwdata[TPOC_C_MODE_B_SH +: 2];
		end
		if (wr_c)
		begin
			nxt_out_mode_d = pwdata[TPOC_C_MODE_D +: 2];
		end
	end

	// force strobes are never stored, only qualified by the non-pwm state
	assign force_a = wr_a && pwdata[TPOC_A_FORCE_A] && !pwm_enable_a_ff;
	assign force_b = wr_a && pwdata[TPOC_A_FORCE_B] && !pwm_enable_b_ff;
	assign force_d = wr_c && pwdata[TPOC_C_FORCE_D] && !pwm_enable_d_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_mode_a_ff <= TPOC_CTRL_RESET[1:0];
			out_mode_b_ff <= TPOC_CTRL_RESET[1:0];
			out_mode_d_ff <= TPOC_CTRL_RESET[1:0];
		end
		else
		begin
			out_mode_a_ff <= nxt_out_mode_a;
			out_mode_b_ff <= nxt_out_mode_b;
			out_mode_d_ff <= nxt_out_mode_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwm_enable_a_ff <= TPOC_CTRL_RESET[TPOC_A_PWM_A];
			pwm_enable_b_ff <= TPOC_CTRL_RESET[TPOC_A_PWM_B];
			pwm_enable_d_ff <= TPOC_CTRL_RESET[TPOC_C_PWM_D];
			gen_mode_ff <= TPOC_CTRL_RESET[1:0];
		end
		else
		begin
			if (wr_a)
			begin
				pwm_enable_a_ff <= pwdata[TPOC_A_PWM_A];
				pwm_enable_b_ff <= pwdata[TPOC_A_PWM_B];
			end
			if (wr_c)
			begin
				pwm_enable_d_ff <= pwdata[TPOC_C_PWM_D];
			end
			if (wr_d)
			begin
				gen_mode_ff <= pwdata[TPOC_D_GEN +: 2];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwm_invert_ff <= TPOC_CTRL_RESET[TPOC_B_INVERT];
			deadtime_div_ff <= TPOC_CTRL_RESET[1:0];
			clk_select_ff <= TPOC_CTRL_RESET[3:0];
			prescaler_reset_strobe_ff <= 1'b0;
		end
		else
		begin
			// hardware drops the strobe after one cycle; writing zero does nothing
			prescaler_reset_strobe_ff <= wr_b && pwdata[TPOC_B_PSR];
			if (wr_b)
			begin
				pwm_invert_ff <= pwdata[TPOC_B_INVERT];
				deadtime_div_ff <= pwdata[TPOC_B_DT_DIV +: 2];
				clk_select_ff <= pwdata[TPOC_B_CLK_SEL +: 4];
			end
		end
	end

	// waveform registers; pwm mode is the per-channel enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wave_a_ff <= 1'b0;
			wave_b_ff <= 1'b0;
			wave_d_ff <= 1'b0;
		end
		else
		begin
			wave_a_ff <= wave_next(nxt_out_mode_a, pwm_enable_a_ff, gen_mode_ff, wave_a_ff,
				compare_match_a, force_a, count_at_bottom, count_down);
			wave_b_ff <= wave_next(nxt_out_mode_b, pwm_enable_b_ff, gen_mode_ff, wave_b_ff,
				compare_match_b, force_b, count_at_bottom, count_down);
			wave_d_ff <= wave_next(nxt_out_mode_d, pwm_enable_d_ff, gen_mode_ff, wave_d_ff,
				compare_match_d, force_d, count_at_bottom, count_down);
		end
	end

	// pins lag the waveform by one cycle so every output leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_a_ff <= 1'b0;
			pin_a_comp_ff <= 1'b0;
			pin_a_oe_n_ff <= 1'b1;
			pin_b_ff <= 1'b0;
			pin_b_comp_ff <= 1'b0;
			pin_b_oe_n_ff <= 1'b1;
			pin_d_ff <= 1'b0;
			pin_d_comp_ff <= 1'b0;
			pin_d_oe_n_ff <= 1'b1;
		end
		else
		begin
			pin_a_ff <= (out_mode_a_ff != TPOC_OM_PORT) ? (wave_a_ff ^ pwm_invert_ff) : port_data_a;
			pin_a_comp_ff <= (pwm_enable_a_ff && out_mode_a_ff == TPOC_OM_TOGGLE) ?
				(!wave_a_ff ^ pwm_invert_ff) : port_data_a;
			pin_a_oe_n_ff <= !port_dir_a;
			pin_b_ff <= (out_mode_b_ff != TPOC_OM_PORT) ? (wave_b_ff ^ pwm_invert_ff) : port_data_b;
			pin_b_comp_ff <= (pwm_enable_b_ff && out_mode_b_ff == TPOC_OM_TOGGLE) ?
				(!wave_b_ff ^ pwm_invert_ff) : port_data_b;
			pin_b_oe_n_ff <= !port_dir_b;
			pin_d_ff <= (out_mode_d_ff != TPOC_OM_PORT) ? (wave_d_ff ^ pwm_invert_ff) : port_data_d;
			pin_d_comp_ff <= (pwm_enable_d_ff && out_mode_d_ff == TPOC_OM_TOGGLE) ?
				(!wave_d_ff ^ pwm_invert_ff) : port_data_d;
			pin_d_oe_n_ff <= !port_dir_d;
		end
	end

	// zero-wait slave: read data and error are prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end
		else
		begin
			pready_ff <= setup_phase;
			pslverr_ff <= setup_phase && !idx_ok;
			prdata_ff <= '0;
			if (setup_phase && !pwrite && idx_ok)
			begin
				if (reg_idx == TPOC_IDX_CTRL_A)
				begin
					prdata_ff[7:0] <= {out_mode_a_ff, out_mode_b_ff, 2'h0, pwm_enable_a_ff, pwm_enable_b_ff};
				end
				else if (reg_idx == TPOC_IDX_CTRL_B)
				begin
					prdata_ff[7:0] <= {pwm_invert_ff, 1'b0, deadtime_div_ff, clk_select_ff};
				end
				else if (reg_idx == TPOC_IDX_CTRL_C)
				begin
					prdata_ff[7:0] <= {out_mode_a_ff, out_mode_b_ff, out_mode_d_ff, 1'b0, pwm_enable_d_ff};
				end
				else
				begin
					prdata_ff[7:0] <= {6'h00, gen_mode_ff};
				end
			end
		end
	end

	// system clock ticks every cycle; the fast timebase arrives as an enable
	assign base_tick = async_clock_mode ? fast_peripheral_tick : 1'b1;

	tpoc_prescaler u_prescaler
	(
		.pclk(pclk),
		.presetn(presetn),
		.base_tick(base_tick),
		.prescaler_clear(prescaler_reset_strobe_ff),
		.clk_select(clk_select_ff),
		.deadtime_div(deadtime_div_ff),
		.timer_tick_ff(timer_tick),
		.deadtime_tick_ff(deadtime_tick)
	);

	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata = prdata_ff;
	assign waveform_out_a = wave_a_ff;
	assign waveform_out_b = wave_b_ff;
	assign waveform_out_d = wave_d_ff;
	assign compare_pin_a = pin_a_ff;
	assign compare_pin_a_comp = pin_a_comp_ff;
	assign compare_pin_a_oe_n = pin_a_oe_n_ff;
	assign compare_pin_b = pin_b_ff;
	assign compare_pin_b_comp = pin_b_comp_ff;
	assign compare_pin_b_oe_n = pin_b_oe_n_ff;
	assign compare_pin_d = pin_d_ff;
	assign compare_pin_d_comp = pin_d_comp_ff;
	assign compare_pin_d_oe_n = pin_d_oe_n_ff;
endmodule
